// File: verilog/pel_port_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Functional notes
// - direction bit one tri-states the pin; zero drives the latch value
// - large package: four-bit port, three pins individually bidirectional
// - bidirectional pin selected as analog reads back zero
// - direction still controls drivers while a pin is analog
// - upper four direction-register bits hold slave port status and mode
// - output latch readable and writable; reads return latch, not pins
// - fuse clear: fourth pin is input only, no direction or latch bit
// - fuse set: fourth pin acts as external reset input
// - fourth pin always senses programming voltage
// - small package: only the fourth input pin, only with fuse clear
// - direction register bit 3 unimplemented, reads zero
// - after reset the three bidirectional pins are analog inputs
// - mode bit enables slave port unless pwm runs dual or quad output
// - each external write end sets input-full and port interrupt flags
// - external read start drives data out and clears output-full
module pel_port_top
    import pel_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [2:0]        pinIn,
    output logic      [2:0]        pinOut,
    output logic      [2:0]        pinOeN,
    input  wire logic              pinThree,
    input  wire logic              vppHigh,
    input  wire logic              masterClearFuse,
    input  wire logic              pwmMultiOut,
    input  wire logic              portDataRead,
    input  wire logic              portDataWritten,
    output logic                   externalResetReq,
    output logic                   progModeDetect,
    output logic                   ibfFlag,
    output logic                   obfFlag,
    output logic                   pspDriveData,
    output logic                   pspEnabled,
    output logic                   irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [5:0]        syncQ;
    logic [2:0]        pinS;
    logic              pin3S;
    logic              vppS;
    logic              fuseS;
    logic [2:0]        latch_q;
    logic [2:0]        dir_q;
    logic [2:0]        ansel_q;
    logic              mode_q;
    logic              input_buffer_overflow_flag_q;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] mask_q;
    logic              awReady_q;
    logic              wReady_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [7:0]        wData_q;
    logic              wStrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arReady_q;
    logic              rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0]        rresp_q;
    logic              ibf_q;
    logic              obf_q;
    logic              irq_q;
    logic              pspEn_q;
    logic              extRst_q;
    logic              prog_q;

    pel_psp_if ev ();

    // pins and the fuse come from outside the clock domain
    pel_sync #(.W(6)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({masterClearFuse, vppHigh, pinThree, pinIn}),
        .q     (syncQ)
    );
    assign pinS  = syncQ[2:0];
    assign pin3S = syncQ[3];
    assign vppS  = syncQ[4];
    assign fuseS = syncQ[5];

    wire pspActive = LARGE_PKG & mode_q & ~pwmMultiOut;

    // strobes are the bidirectional pins themselves while in slave mode
    pel_psp_det u_det (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (pspActive),
        .rdN    (pinS[0]),
        .wrN    (pinS[1]),
        .csN    (pinS[2]),
        .ev     (ev.det)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire [ADDR_W-1:0] wAddr  = {awAddr_q[ADDR_W-1:2], 2'b00};
    wire [ADDR_W-1:0] rAddr  = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wire wrDo     = ~awReady_q & ~wReady_q & ~bvalid_q;
    wire wrEn     = wrDo & wStrb_q;
    wire selLevel = wAddr == OFF_LEVEL;
    wire selLatch = wAddr == OFF_LATCH;
    wire selDir   = wAddr == OFF_DIR;
    wire selAnsel = wAddr == OFF_ANSEL;
    wire selStat  = wAddr == OFF_STAT;
    wire selMask  = wAddr == OFF_MASK;
    wire wMapped  = selLevel | selLatch | selDir | selAnsel | selStat |
                    selMask;
    wire arDo     = s_axi_arvalid & arReady_q;
    wire rMapped  = (rAddr == OFF_LEVEL) | (rAddr == OFF_LATCH) |
                    (rAddr == OFF_DIR) | (rAddr == OFF_ANSEL) |
                    (rAddr == OFF_STAT) | (rAddr == OFF_MASK);
    wire statRdClr = arDo & (rAddr == OFF_STAT);

    // pin-level view; analog pins and absent pins read zero
    wire [2:0] bidirVal = LARGE_PKG ? (pinS & ~ansel_q) : 3'h0;
    wire       pin3Val  = pin3S & ~fuseS;
    wire [7:0] levelVal = {4'h0, pin3Val, bidirVal};
    wire [7:0] dirVal   = {ibf_q, obf_q, input_buffer_overflow_flag_q, mode_q, 1'b0, dir_q};
    wire [7:0] latchVal = {5'h00, latch_q};
    wire [7:0] rdMux =
        (rAddr == OFF_LEVEL) ? levelVal :
        (rAddr == OFF_LATCH) ? latchVal :
        (rAddr == OFF_DIR)   ? dirVal :
        (rAddr == OFF_ANSEL) ? {5'h00, ansel_q} :
        (rAddr == OFF_STAT)  ? {6'h00, stat_q} :
        (rAddr == OFF_MASK)  ? {6'h00, mask_q} : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awReady_q <= 1'b1;
            wReady_q  <= 1'b1;
            awAddr_q  <= '0;
            wData_q   <= 8'h00;
            wStrb_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awReady_q) begin
                awReady_q <= 1'b0;
                awAddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wReady_q) begin
                wReady_q <= 1'b0;
                wData_q  <= s_axi_wdata[7:0];
                wStrb_q  <= s_axi_wstrb[0];
            end
            if (wrDo) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wMapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awReady_q <= 1'b1;
                wReady_q  <= 1'b1;
            end
        end
    end

    // read channel: one read in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arReady_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (arDo) begin
            arReady_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {24'h000000, rdMux};
            rresp_q   <= rMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            arReady_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers; both data addresses write the latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= LATCH_RST;
            dir_q   <= DIR_RST;
            ansel_q <= ANSEL_RST;
            mode_q  <= 1'b0;
            mask_q  <= '0;
        end else if (wrEn) begin
            if (selLevel || selLatch)
                latch_q <= wData_q[2:0];
            // small package keeps all drivers off
            if (selDir && LARGE_PKG) begin
                dir_q  <= wData_q[2:0];
                mode_q <= wData_q[DIR_MODE];
            end
            if (selAnsel)
                ansel_q <= wData_q[2:0];
            if (selMask)
                mask_q <= wData_q[STAT_W-1:0];
        end
    end

    // hardware flags: a set in the same cycle as a clear wins, except obf, whose set is ignored while a read is active
    wire ibovSet = ev.wrEnd & ibf_q;
    wire ibovClr = wrEn & selDir & ~wData_q[DIR_INPUT_BUFFER_OVERFLOW_FLAG];
    wire ibfClr  = portDataRead;
    wire obfSet  = portDataWritten & ~ev.rdActive;
    wire [STAT_W-1:0] statSet = {ibovSet, ev.wrEnd | ev.rdEnd};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ibf_q  <= 1'b0;
            obf_q  <= 1'b0;
            input_buffer_overflow_flag_q <= 1'b0;
            stat_q <= '0;
        end else begin
            ibf_q  <= ev.wrEnd | (ibf_q & ~ibfClr);
            obf_q  <= obfSet | (obf_q & ~ev.rdStart);
            input_buffer_overflow_flag_q <= ibovSet | (input_buffer_overflow_flag_q & ~ibovClr);
            stat_q <= statSet | (stat_q & ~{STAT_W{statRdClr}});
        end
    end

    // pin roles of the fourth pin, and status toward neighbours
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q    <= 1'b0;
            pspEn_q  <= 1'b0;
            extRst_q <= 1'b0;
            prog_q   <= 1'b0;
        end else begin
            irq_q    <= |(stat_q & mask_q);
            pspEn_q  <= pspActive;
            extRst_q <= fuseS & ~pin3S;
            prog_q   <= vppS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign s_axi_awready    = awReady_q;
    assign s_axi_wready     = wReady_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = arReady_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    // analog selection has no say over the drivers
    assign pinOut           = latch_q;
    assign pinOeN           = dir_q;
    assign pspDriveData     = ev.rdActive;
    assign ibfFlag          = ibf_q;
    assign obfFlag          = obf_q;
    assign pspEnabled       = pspEn_q;
    assign externalResetReq = extRst_q;
    assign progModeDetect   = prog_q;
    assign irq              = irq_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_dirOe;
        wrEn && selDir && !wData_q[0] |=> !pinOeN[0] || !LARGE_PKG;
    endproperty
    a_dirOe: assert property (p_dirOe) else $error("dir0 not driving");

    property p_anaZero;
        arDo && rAddr == OFF_LEVEL && ansel_q[1] |=> !s_axi_rdata[1];
    endproperty
    a_anaZero: assert property (p_anaZero) else $error("analog bit");

    property p_bit3;
        arDo && rAddr == OFF_DIR |=> s_axi_rvalid && !s_axi_rdata[3];
    endproperty
    a_bit3: assert property (p_bit3) else $error("dir bit3 set");

    property p_ibf;
        ev.wrEnd |=> ibfFlag && stat_q[ST_PIF];
    endproperty
    a_ibf: assert property (p_ibf) else $error("ibf not set");

    property p_obf;
        ev.rdStart && !portDataWritten |=> !obfFlag;
    endproperty
    a_obf: assert property (p_obf) else $error("obf not cleared");

    property p_input_buffer_overflow_flag;
        ev.wrEnd && ibfFlag |=> input_buffer_overflow_flag_q ##1 (input_buffer_overflow_flag_q || $past(ibovClr));
    endproperty
    a_input_buffer_overflow_flag: assert property (p_input_buffer_overflow_flag) else $error("overflow lost");

    property p_mode;
        mode_q && pwmMultiOut |=> !pspEnabled;
    endproperty
    a_mode: assert property (p_mode) else $error("slave port on");

    property p_external_reset_input;
        fuseS && !pin3S |=> externalResetReq;
    endproperty
    a_external_reset_input: assert property (p_external_reset_input) else $error("reset missed");

    property p_latch;
        arDo && rAddr == OFF_LATCH |=> s_axi_rdata[2:0] == $past(latch_q);
    endproperty
    a_latch: assert property (p_latch) else $error("latch readback");

    property p_small;
        !LARGE_PKG |-> pinOeN == DIR_RST;
    endproperty
    a_small: assert property (p_small) else $error("small pkg drives");

    c_write: cover property (ev.wrEnd ##1 ibfFlag);
    c_read:  cover property (ev.rdStart ##[1:20] ev.rdEnd);
    c_ovf:   cover property (ibovSet);
    c_irq:   cover property (statRdClr && irq);
endmodule : pel_port_top

// File: verilog/pel_pkg.sv
package pel_pkg;
    localparam int          ADDR_W     = 5;
    localparam int          DATA_W     = 32;
    localparam int          BIDIR_N    = 3;
    localparam int          STAT_W     = 2;
    // register byte offsets
    localparam logic [4:0]  OFF_LEVEL  = 5'h00;
    localparam logic [4:0]  OFF_LATCH  = 5'h04;
    localparam logic [4:0]  OFF_DIR    = 5'h08;
    localparam logic [4:0]  OFF_ANSEL  = 5'h0c;
    localparam logic [4:0]  OFF_STAT   = 5'h10;
    localparam logic [4:0]  OFF_MASK   = 5'h14;
    // fields of the direction register
    localparam int          DIR_IBF    = 7;
    localparam int          DIR_OBF    = 6;
    localparam int          DIR_INPUT_BUFFER_OVERFLOW_FLAG   = 5;
    localparam int          DIR_MODE   = 4;
    // status bits
    localparam int          ST_PIF     = 0;
    localparam int          ST_OVF     = 1;
    // reset values
    localparam logic [2:0]  DIR_RST    = 3'h7;
    localparam logic [2:0]  ANSEL_RST  = 3'h7;
    localparam logic [2:0]  LATCH_RST  = 3'h0;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_WR   = 2'h1,
        BUS_RD   = 2'h2
    } pel_bus_e;
endpackage : pel_pkg

// File: verilog/pel_psp_if.sv
`timescale 1ns/1ps
interface pel_psp_if;
    logic wrEnd;
    logic rdStart;
    logic rdEnd;
    logic rdActive;
    modport det  (output wrEnd, output rdStart, output rdEnd,
                  output rdActive);
    modport core (input wrEnd, input rdStart, input rdEnd,
                  input rdActive);
endinterface : pel_psp_if

// File: verilog/pel_sync.sv
`timescale 1ns/1ps
module pel_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[i] <= 1'b0;
                    q[i]      <= 1'b0;
                end else begin
                    meta_q[i] <= d[i];
                    q[i]      <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule : pel_sync

// File: verilog/pel_psp_det.sv
`timescale 1ns/1ps
module pel_psp_det
    import pel_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic rdN,
    input  wire logic wrN,
    input  wire logic csN,
    pel_psp_if.det    ev
);
    pel_bus_e state_q;
    pel_bus_e state_d;
    logic     wrEnd_q;
    logic     rdStart_q;
    logic     rdEnd_q;
    // kept beside state_q so the data-drive output leaves a flop directly
    logic     rdActive_q;
    wire      wrAct = enable & ~csN & ~wrN;
    wire      rdAct = enable & ~csN & ~rdN;

    // a write takes priority when both strobes fall together
    always_comb begin
        state_d = state_q;
        case (state_q)
            BUS_IDLE: begin
                if (wrAct) state_d = BUS_WR;
                else if (rdAct) state_d = BUS_RD;
            end
            BUS_WR:  if (!wrAct) state_d = BUS_IDLE;
            BUS_RD:  if (!rdAct) state_d = BUS_IDLE;
            default: state_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= BUS_IDLE;
            wrEnd_q   <= 1'b0;
            rdStart_q <= 1'b0;
            rdEnd_q   <= 1'b0;
            rdActive_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            wrEnd_q   <= (state_q == BUS_WR) && !wrAct;
            rdStart_q <= (state_q == BUS_IDLE) && !wrAct && rdAct;
            rdEnd_q   <= (state_q == BUS_RD) && !rdAct;
            rdActive_q <= (state_d == BUS_RD);
        end
    end

    assign ev.wrEnd    = wrEnd_q;
    assign ev.rdStart  = rdStart_q;
    assign ev.rdEnd    = rdEnd_q;
    assign ev.rdActive = rdActive_q;
endmodule : pel_psp_det

// File: tb/pel_ext_pins.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// external circuitry on the three bidirectional pins
module pel_ext_pins (
    input  wire logic       clk,
    input  wire logic [2:0] pinOut,
    input  wire logic [2:0] pinOeN,
    output logic      [2:0] pinIn
);
    logic [2:0] extLvl;

    // strobes idle high, as the far side keeps them deasserted
    initial extLvl = 3'h7;

    task automatic drive(input logic [2:0] lvl);
        @(posedge clk);
        extLvl <= lvl;
    endtask : drive

    // a pin whose driver is on shows the latch value; otherwise the
    // far side owns the level
    assign pinIn = (~pinOeN & pinOut) | (pinOeN & extLvl);
endmodule : pel_ext_pins

// File: tb/pel_port_top_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module pel_port_top_test;
    import pel_pkg::*;
    logic              clk, rst_n, awValid, awReady, wValid, wReady;
    logic              bValid, bReady, arValid, arReady, rValid, rReady;
    logic [ADDR_W-1:0] awAddr, arAddr;
    logic [DATA_W-1:0] wData, rData;
    logic [3:0]        wStrb;
    logic [1:0]        bResp, rResp;
    logic [2:0]        pinIn, pinOut, pinOeN;
    logic              pinThree, vppHigh, fuse, pwmMulti, dataRd, dataWr;
    logic              extRst, progDet, input_buffer_full_flag, output_buffer_full_flag, pspDrive, pspEn, irq;
    int                failCount, cmpCount, cycles;

    pel_port_top #(.LARGE_PKG(1'b1)) DUT (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
        .pinThree(pinThree), .vppHigh(vppHigh), .masterClearFuse(fuse),
        .pwmMultiOut(pwmMulti), .portDataRead(dataRd),
        .portDataWritten(dataWr), .externalResetReq(extRst),
        .progModeDetect(progDet), .ibfFlag(input_buffer_full_flag), .obfFlag(output_buffer_full_flag),
        .pspDriveData(pspDrive), .pspEnabled(pspEn), .irq(irq)
    );

    pel_ext_pins ext (
        .clk(clk), .pinOut(pinOut), .pinOeN(pinOeN), .pinIn(pinIn)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tallyAndFinish();
        if (failCount == 0 && cmpCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tallyAndFinish

    // a hung handshake ends up here rather than running forever
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            tallyAndFinish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
    endtask : waitClk

    ////////////////////////////////////////////////////////////////////////
    task automatic axiWr(input logic [4:0] a, input logic [31:0] d,
                         input logic [1:0] expResp = RESP_OKAY);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awAddr  <= a;
        awValid <= 1'b1;
        wData   <= d;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid && bReady) begin
                bReady <= 1'b0;
                done = 1'b1;
                check(bResp, expResp);
            end
        end
    endtask : axiWr

    task automatic axiRd(input logic [4:0] a, output logic [31:0] d,
                         output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge clk);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid && rReady) begin
                rReady <= 1'b0;
                d = rData;
                resp = rResp;
                done = 1'b1;
            end
        end
    endtask : axiRd

    task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axiRd(a, d, r);
        check(r, RESP_OKAY);
        check(d, exp);
    endtask : rdChk

    // strobes are synced, so each phase is held well past the sync delay
    task automatic extCycle(input logic [2:0] active);
        ext.drive(active);
        waitClk(6);
        ext.drive(3'h7);
        waitClk(8);
    endtask : extCycle

    ////////////////////////////////////////////////////////////////////////
    task automatic tResetVals();
        rdChk(OFF_DIR, 32'h7);
        rdChk(OFF_ANSEL, 32'h7);
        rdChk(OFF_LATCH, 32'h0);
        rdChk(OFF_MASK, 32'h0);
        check(pinOeN, 3'h7);
    endtask : tResetVals

    task automatic tDrive();
        axiWr(OFF_ANSEL, 32'h0);
        axiWr(OFF_LATCH, 32'h7);
        axiWr(OFF_DIR, 32'h2);
        ext.drive(3'h5);
        pinThree <= 1'b1;
        waitClk(4);
        check(pinOeN, 3'h2);
        check(pinOut, 3'h7);
        rdChk(OFF_LEVEL, 32'hd);
        rdChk(OFF_LATCH, 32'h7);
    endtask : tDrive

    task automatic tAnalog();
        axiWr(OFF_ANSEL, 32'h2);
        ext.drive(3'h7);
        waitClk(4);
        rdChk(OFF_LEVEL, 32'hd);
        axiWr(OFF_DIR, 32'h0);
        axiWr(OFF_ANSEL, 32'h7);
        waitClk(2);
        check(pinOeN, 3'h0);
        axiWr(OFF_DIR, 32'h7);
        waitClk(2);
        check(pinOeN, 3'h7);
    endtask : tAnalog

    task automatic tCtrl();
        axiWr(OFF_DIR, 32'hdf);
        rdChk(OFF_DIR, 32'h17);
        waitClk(2);
        check(pspEn, 1'b1);
        pwmMulti <= 1'b1;
        waitClk(3);
        check(pspEn, 1'b0);
        pwmMulti <= 1'b0;
        waitClk(3);
        check(pspEn, 1'b1);
    endtask : tCtrl

    task automatic tPspWrite();
        axiWr(OFF_MASK, 32'h1);
        extCycle(3'h1);
        check(input_buffer_full_flag, 1'b1);
        check(irq, 1'b1);
        rdChk(OFF_STAT, 32'h1);
        waitClk(3);
        check(irq, 1'b0);
        extCycle(3'h1);
        rdChk(OFF_DIR, 32'hb7);
        axiWr(OFF_MASK, 32'h0);
        waitClk(3);
        check(irq, 1'b0);
        rdChk(OFF_STAT, 32'h3);
        axiWr(OFF_DIR, 32'h17);
        rdChk(OFF_DIR, 32'h97);
        @(posedge clk);
        dataRd <= 1'b1;
        @(posedge clk);
        dataRd <= 1'b0;
        waitClk(3);
        check(input_buffer_full_flag, 1'b0);
    endtask : tPspWrite

    task automatic tPspRead();
        @(posedge clk);
        dataWr <= 1'b1;
        @(posedge clk);
        dataWr <= 1'b0;
        waitClk(3);
        check(output_buffer_full_flag, 1'b1);
        ext.drive(3'h2);
        waitClk(8);
        check(pspDrive, 1'b1);
        check(output_buffer_full_flag, 1'b0);
        ext.drive(3'h7);
        waitClk(8);
        check(pspDrive, 1'b0);
        rdChk(OFF_STAT, 32'h1);
    endtask : tPspRead

    task automatic tFuse();
        fuse <= 1'b1;
        pinThree <= 1'b0;
        waitClk(5);
        check(extRst, 1'b1);
        pinThree <= 1'b1;
        waitClk(5);
        check(extRst, 1'b0);
        rdChk(OFF_LEVEL, 32'h0);
        vppHigh <= 1'b1;
        waitClk(4);
        check(progDet, 1'b1);
        fuse <= 1'b0;
        waitClk(4);
        rdChk(OFF_LEVEL, 32'h8);
        vppHigh <= 1'b0;
        waitClk(4);
        check(progDet, 1'b0);
    endtask : tFuse

    task automatic tUnmapped();
        logic [31:0] d;
        logic [1:0]  r;
        // low byte lane off: answered okay, latch keeps its value
        wStrb <= 4'he;
        axiWr(OFF_LATCH, 32'h0);
        wStrb <= 4'hf;
        rdChk(OFF_LATCH, 32'h7);
        axiWr(OFF_LEVEL, 32'h5);
        rdChk(OFF_LATCH, 32'h5);
        check(pinOut, 3'h5);
        axiWr(5'h18, 32'hff, RESP_SLVERR);
        axiRd(5'h18, d, r);
        check(r, RESP_SLVERR);
        check(d, 32'h0);
    endtask : tUnmapped

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {awValid, wValid, bReady, arValid, rReady} = 5'h0;
        awAddr = 5'h0;
        arAddr = 5'h0;
        wData = 32'h0;
        wStrb = 4'hf;
        {pinThree, vppHigh, fuse, pwmMulti, dataRd, dataWr} = 6'h0;
        failCount = 0;
        cmpCount = 0;
        cycles = 0;
        waitClk(5);
        rst_n <= 1'b1;
        @(posedge clk);
        tResetVals();
        tDrive();
        tAnalog();
        tCtrl();
        tPspWrite();
        tPspRead();
        tFuse();
        tUnmapped();
        tallyAndFinish();
    end
endmodule : pel_port_top_test
